// ===== include/cod_pkg.sv
// Constants for the divided clock output block
package cod_pkg;
  localparam int unsigned RATIO_W        = 8;
  localparam logic [7:0]  RATIO_RESET    = 8'h00;
  localparam logic [7:0]  SILENT_RATIO   = 8'h1F; // Divide by 32 less one
  localparam logic        SRC_SYSTEM     = 1'h0;
  localparam logic        SRC_INTERNAL   = 1'h1;
  localparam logic        SRC_RESET      = 1'h0;
  localparam int unsigned SYNC_STAGES    = 3;
endpackage

// ===== src/cod_divider.sv
// Divided clock output with the documented zero-ratio silicon behaviour
`timescale 1ns/100ps
// Function
// RULE1: Ratio field divides source by value plus one
// RULE2: Source select zero system, one internal oscillator
// RULE3: Ratio never written nonzero divides by 32
// RULE4: Ratio changed to zero keeps previous ratio
// RULE5: Divided clock drives a general-purpose pin
// RULE6: Software prefers nonzero ratio and other source
// RULE7: Counter on source toggles output each half
module cod_divider (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       internal_precision_oscillator,
  input  wire logic       source_select,
  input  wire logic [7:0] ratio,
  output logic            gpio_clk_out,
  output logic            gpio_clk_oe
);

  // Tick counter is one bit wider than the ratio so 256 ticks fit
  localparam int unsigned       CNT_W    = cod_pkg::RATIO_W + 1;
  localparam logic [CNT_W-1:0]  CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0]  CNT_ZERO = CNT_W'(0);

  // Whether a nonzero ratio has been seen since reset
  typedef enum logic [0:0] {
    HIST_FRESH, // Only zero seen: silent divide by 32
    HIST_HELD   // A nonzero ratio is latched
  } cod_hist_t;

  // True when the select field picks the internal oscillator
  function automatic logic src_is_internal(input logic sel);
    return (sel == cod_pkg::SRC_INTERNAL);
  endfunction

  // True when the ratio field holds the value that is never latched
  function automatic logic ratio_is_zero(input logic [7:0] value);
    return (value == 8'h00);
  endfunction

  // Source ticks in one output period: the ratio plus one
  function automatic logic [CNT_W-1:0] period_of(input logic [7:0] value);
    return {1'b0, value} + CNT_ONE;
  endfunction

  // Oscillator level after the synchroniser
  logic             osc_sync;
  logic             osc_stable;
  logic             osc_rise;
  logic             src_tick;

  // Tick source state
  logic             osc_prev_q;
  logic             osc_prev_d;

  // Ratio history state
  cod_hist_t        hist_q;
  cod_hist_t        hist_d;
  logic [7:0]       eff_q;
  logic [7:0]       eff_d;

  // Counter state and its decoded boundaries
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] half;
  logic             at_wrap;
  logic             at_half;

  // Pin state
  logic             out_q;
  logic             out_d;
  logic             oe_q;
  logic             oe_d;

  // Oscillator crosses in through three flip-flops
  // It must run below a quarter of mclk for every edge to be seen
  cod_sync u_osc_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (internal_precision_oscillator),
    .dout    (osc_sync),
    .stable  (osc_stable)
  );

  // Settled rising oscillator edges; the last level holds while unsettled
  always_comb begin
    osc_prev_d = osc_prev_q;
    osc_rise   = 1'b0;
    if (osc_stable) begin
      osc_prev_d = osc_sync;
      osc_rise   = osc_sync & ~osc_prev_q;
    end
    if (src_is_internal(source_select)) begin // RULE2
      src_tick = osc_rise;
    end else begin
      src_tick = 1'b1; // RULE2
    end
  end

  // Two ticks can never fall in adjacent cycles on the oscillator path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_prev_d;
    end
  end

  // Latch each nonzero ratio; zero leaves the ratio in force unchanged
  // Divide by one is unreachable, since zero is never latched
  always_comb begin
    hist_d = hist_q;
    eff_d  = eff_q;
    case (hist_q)
      HIST_FRESH: begin
        if (!ratio_is_zero(ratio)) begin
          hist_d = HIST_HELD;
          eff_d  = ratio; // RULE1
        end else begin
          eff_d  = cod_pkg::SILENT_RATIO; // RULE3
        end
      end
      HIST_HELD: begin
        if (!ratio_is_zero(ratio)) begin
          eff_d = ratio; // RULE1
        end else begin
          eff_d = eff_q; // RULE4
        end
      end
      default: begin
        hist_d = HIST_FRESH;
        eff_d  = cod_pkg::SILENT_RATIO;
      end
    endcase
  end

  // Reset forgets the history, so zero again means divide by 32
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hist_q <= HIST_FRESH;
      eff_q  <= cod_pkg::SILENT_RATIO; // RULE3
    end else begin
      hist_q <= hist_d;
      eff_q  <= eff_d;
    end
  end

  // Boundaries of the latched ratio
  // Even ratios leave the low half one tick shorter than the high half
  always_comb begin
    period  = period_of(eff_q); // RULE1
    half    = period >> 1;
    cnt_inc = cnt_q + CNT_ONE;
    at_wrap = (cnt_inc >= period);
    at_half = (cnt_inc == half);
  end

  // Count source ticks and restart at the end of each period
  always_comb begin
    cnt_d = cnt_q;
    if (src_tick) begin // RULE7
      if (at_wrap) begin
        cnt_d = CNT_ZERO;
      end else begin
        cnt_d = cnt_inc;
      end
    end
  end

  // A ratio cut below the count wraps at the next tick
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Low for the first half, high from the half point to the wrap
  always_comb begin
    out_d = out_q;
    if (src_tick) begin // RULE7
      if (at_wrap) begin
        out_d = 1'b0;
      end else if (at_half) begin
        out_d = 1'b1;
      end else begin
        out_d = out_q;
      end
    end
  end

  // Output register feeds the pin with no logic after it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // Pin is driven from the first edge after reset onwards
  always_comb begin
    oe_d = 1'b1; // RULE5
  end

  // Enable stays low through reset so the pin floats
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // Both pin signals come straight from flip-flops
  assign gpio_clk_out = out_q; // RULE5
  assign gpio_clk_oe  = oe_q;  // RULE5
endmodule // cod_divider

// ===== src/cod_sync.sv
// Three-stage synchroniser for an input from another clock domain
`timescale 1ns/100ps
module cod_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout,
  output logic      stable
);
  logic [cod_pkg::SYNC_STAGES-1:0] sh_q;
  logic [cod_pkg::SYNC_STAGES-1:0] sh_d;

  // Shift in; first stage is read only by the second
  always_comb begin
    sh_d = {sh_q[cod_pkg::SYNC_STAGES-2:0], din};
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_d;
    end
  end

  // Second and third stages must agree
  assign dout   = sh_q[cod_pkg::SYNC_STAGES-1];
  assign stable = (sh_q[cod_pkg::SYNC_STAGES-2] ==
                   sh_q[cod_pkg::SYNC_STAGES-1]);
endmodule // cod_sync

// ===== verification/cod_checker.sv
// Pin checks for the divided clock output
`timescale 1ns/100ps
module cod_checker (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       source_select,
  input wire logic [7:0] ratio,
  input wire logic       gpio_clk_out,
  input wire logic       gpio_clk_oe
);
  AST_QUIET: assert property (@(posedge mclk)
    sys_rst |=> !gpio_clk_oe)
    else $error("pin driven in reset");
  AST_LOW: assert property (@(posedge mclk)
    sys_rst |=> !gpio_clk_out)
    else $error("output high in reset");
  AST_OE: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> gpio_clk_oe)
    else $error("pin not driven");
  // The oscillator may be slow, so only the system source is timed
  AST_RUN: assert property (@(posedge mclk)
    disable iff (sys_rst || source_select)
    gpio_clk_oe |-> ##[1:400] $changed(gpio_clk_out))
    else $error("output stuck");
  AST_DIV2: assert property (@(posedge mclk) disable iff (sys_rst)
    (!source_select && ratio == 8'h01)[*4] |->
    gpio_clk_out != $past(gpio_clk_out))
    else $error("ratio one does not halve");
  AST_TICK: assert property (@(posedge mclk) disable iff (sys_rst)
    source_select && $past(source_select) && $changed(gpio_clk_out)
    |=> $stable(gpio_clk_out))
    else $error("oscillator source stepped twice");
endmodule // cod_checker
bind cod_divider cod_checker u_chk (.mclk, .sys_rst, .source_select, .ratio,
  .gpio_clk_out, .gpio_clk_oe);

// ===== verification/cod_receiver.sv
// Model of the pin receiver; times the clock
`timescale 1ns/100ps
module cod_receiver (
  input  wire logic mclk,
  input  wire logic pin,
  input  wire logic oe,
  output int        period,
  output int        since
);
  int   n = 0;
  logic last = 1'b0;
  logic seen;
  // An undriven pin reads low through its pull-down
  assign seen = oe & pin;
  // Cycles between rising edges, and cycles since the last one
  always @(posedge mclk) begin
    n      <= (seen && !last) ? 1 : n + 1;
    period <= (seen && !last) ? n : period;
    last   <= seen;
  end
  assign since = n;
endmodule // cod_receiver

// ===== verification/tb_top.sv
// Bench of the divided clock output
`timescale 1ns/100ps
module tb_top;
  logic mclk = 0, sys_rst = 1, osc = 0, src = 0, out, oe;
  logic [7:0] r = 8'h00;
  int per, since, fails = 0, n_tests = 0, cyc = 0;
  int rows[5][3] = '{'{0,4,5}, '{0,1,2}, '{1,3,32}, '{1,1,16}, '{0,255,256}};
  initial forever #12.5 mclk = ~mclk;
  initial forever #100 osc = ~osc;
  cod_divider u_cod_divider (.mclk, .sys_rst,
    .internal_precision_oscillator(osc), .source_select(src), .ratio(r),
    .gpio_clk_out(out), .gpio_clk_oe(oe));
  cod_receiver u_cod_receiver (.mclk, .pin(out), .oe, .period(per),
    .since);
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("Error %0t %0h %0h", $time, s, e);
    end
  endtask
  task automatic run(input int s, input int v, input int e);
    @(negedge mclk);
    src = s[0];
    r = v[7:0];
    repeat (2 * e + 300) @(negedge mclk);
    check(per, e);
    check((since <= e), 1);
  endtask
  task automatic close_out();
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge mclk) if (cyc++ == 8000) begin
    fails++;
    close_out();
  end
  initial begin
    repeat (3) @(negedge mclk);
    check(oe, 0);
    check(out, 0);
    sys_rst = 0;
    for (int i = 0; i < 5; i++) begin
      run(rows[i][0], rows[i][1], rows[i][2]);
    end
    check(oe, 1);
    run(0, 0, 256);
    run(1, 1, 16);
    run(1, 0, 16);
    sys_rst = 1;
    repeat (3) @(negedge mclk);
    check(oe, 0);
    check(out, 0);
    sys_rst = 0;
    run(0, 0, 32);
    run(1, 0, 256);
    close_out();
  end
endmodule // tb_top
